// *** hw/fra_consts.vh ***
/*
 * Constants for the flash region map and access permission logic:
 * region bases, page geometry, wait-state threshold and timing counts.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef FRA_CONSTS_VH
`define FRA_CONSTS_VH

`define FRA_MAIN_BASE      32'h00000000
`define FRA_MAIN_TOP       32'h00008000
`define FRA_MAIN_LAST_PAGE 32'h00007C00
`define FRA_INFO_BASE      32'h0FE00000
`define FRA_INFO_TOP       32'h0FE10000
`define FRA_USER_BASE      32'h0FE00000
`define FRA_LOCK_BASE      32'h0FE04000
`define FRA_DEVINFO_BASE   32'h0FE08000
`define FRA_PAGE_BYTES     1024
`define FRA_PAGE_SHIFT     10
`define FRA_MAIN_PAGES     32
`define FRA_WS_LIMIT_HZ    16000000

// Region codes
`define FRA_RG_NONE    3'h0
`define FRA_RG_MAIN    3'h1
`define FRA_RG_USER    3'h2
`define FRA_RG_LOCK    3'h3
`define FRA_RG_DEVINFO 3'h4

// Operation codes
`define FRA_OP_READ  2'h0
`define FRA_OP_WRITE 2'h1
`define FRA_OP_ERASE 2'h2
`define FRA_OP_MASS  2'h3

// Energy states
`define FRA_EM_RUN   2'h0
`define FRA_EM_SLEEP 2'h1

// Masters
`define FRA_MS_CORE  2'h0
`define FRA_MS_DMA   2'h1
`define FRA_MS_DEBUG 2'h2

// Default flash operation times in reference clock cycles
`define FRA_WRITE_CYCLES 16'h0010
`define FRA_ERASE_CYCLES 16'h0100
`define FRA_SRAM_CYCLES  16'h0040

`endif

// *** hw/fra_decode.v ***
/*
 * Address decoder: maps a byte address to a flash region and page index.
 * Assumes a 32-bit byte address; purely combinational.
 */
`include "fra_consts.vh"
`default_nettype none

module fra_decode (
    input  wire [31:0] i_addr,
    output reg  [2:0]  o_region,
    output wire [4:0]  o_page
);

    // Page index sits above the tenth address bit
    assign o_page = i_addr[`FRA_PAGE_SHIFT+4:`FRA_PAGE_SHIFT];

    // Region match; reserved gaps fall through to none
    always @* begin
        o_region = `FRA_RG_NONE;
        if (i_addr < `FRA_MAIN_TOP) begin
            o_region = `FRA_RG_MAIN;
        end else if (i_addr >= `FRA_USER_BASE && i_addr < `FRA_USER_BASE + `FRA_PAGE_BYTES) begin
            o_region = `FRA_RG_USER;
        end else if (i_addr >= `FRA_LOCK_BASE && i_addr < `FRA_LOCK_BASE + `FRA_PAGE_BYTES) begin
            o_region = `FRA_RG_LOCK;
        end else if (i_addr >= `FRA_DEVINFO_BASE && i_addr < `FRA_DEVINFO_BASE + `FRA_PAGE_BYTES) begin
            o_region = `FRA_RG_DEVINFO;
        end
    end

endmodule

`default_nettype wire

// *** hw/fra_access.v ***
/*
 * Flash region map and access permission logic. Takes one request at a
 * time, checks region, master, operation and energy state, runs a timed
 * write or erase sequence, and reports completion, events and errors.
 * Assumes a single 50 MHz clock and that requesters hold i_req_valid
 * until o_req_ready; the flash array itself sits outside this block.
 */
// How it works
// - Main at zero, info block at high base
// - Pages are 1024 bytes, index from bit ten up
// - Main block up to 32 pages
// - Space above main and info is reserved
// - User data page readable, writable, erasable
// - Lock page: write any, erase debug only
// - Device info page is read only
// - Device erase clears every main page
// - Device erase leaves user data page alone
// - Page erase command clears user data page
// - Core and DMA both read and write
// - Access only in run or sleep states
// - Zero wait up to 16 MHz, else one
// - Core writes only in run; DMA also sleep
// - Pulse events at end of write, erase
// - Optional page erase abort on interrupt
// - Device erase: main, SRAM, then lock page
`include "fra_consts.vh"
`default_nettype none

module fra_access #(
    parameter        CORE_HZ      = 14000000,
    parameter [15:0] WRITE_CYCLES = `FRA_WRITE_CYCLES,
    parameter [15:0] ERASE_CYCLES = `FRA_ERASE_CYCLES,
    parameter [15:0] SRAM_CYCLES  = `FRA_SRAM_CYCLES
) (
    input  wire        i_ref_clk,
    input  wire        i_rst,
    input  wire        i_req_valid,
    input  wire [1:0]  i_req_master,
    input  wire [1:0]  i_req_op,
    input  wire [31:0] i_req_addr,
    input  wire [1:0]  i_energy_state,
    input  wire        i_erase_abort_en,
    input  wire        i_irq_pending,
    output reg         o_req_ready,
    output reg         o_done,
    output reg         o_bus_error,
    output reg  [1:0]  o_wait_states,
    output reg         o_flash_rd,
    output reg         o_flash_wr,
    output reg         o_flash_erase,
    output reg  [2:0]  o_flash_region,
    output reg  [4:0]  o_flash_page,
    output reg         o_sram_clear,
    output reg         o_write_done_evt,
    output reg         o_erase_done_evt,
    output reg         o_erase_aborted,
    output reg         o_erase_busy
);

    // Sequencer states
    localparam ST_IDLE  = 3'h0;
    localparam ST_READ  = 3'h1;
    localparam ST_WRITE = 3'h2;
    localparam ST_ERASE = 3'h3;
    localparam ST_MMAIN = 3'h4;
    localparam ST_MSRAM = 3'h5;
    localparam ST_MLB   = 3'h6;
    localparam ST_DONE  = 3'h7;

    // Wait states fixed by the core clock rate at build time
    localparam [1:0] WS = (CORE_HZ > `FRA_WS_LIMIT_HZ) ? 2'h1 : 2'h0;

    // Region and page of the address on the request lines
    wire [2:0] dec_region;
    wire [4:0] dec_page;

    fra_decode u_decode (
        .i_addr   (i_req_addr),
        .o_region (dec_region),
        .o_page   (dec_page)
    );

    // Permission check for one request
    function allowed;
        input [1:0] master;
        input [1:0] op;
        input [2:0] region;
        input [1:0] em;
        reg         em_ok;
        begin
            em_ok = (em == `FRA_EM_RUN) || (em == `FRA_EM_SLEEP);
            allowed = 1'b0;
            if (!em_ok) begin
                allowed = 1'b0;
            end else if (op == `FRA_OP_READ) begin
                allowed = (region != `FRA_RG_NONE);
            end else if (op == `FRA_OP_MASS) begin
                allowed = (master == `FRA_MS_DEBUG);
            end else if (master == `FRA_MS_CORE && em != `FRA_EM_RUN) begin
                allowed = 1'b0;
            end else if (master != `FRA_MS_CORE && master != `FRA_MS_DEBUG && op == `FRA_OP_ERASE) begin
                // DMA and the spare master code write but never erase
                allowed = 1'b0;
            end else begin
                case (region)
                    `FRA_RG_MAIN:    allowed = 1'b1;
                    `FRA_RG_USER:    allowed = 1'b1;
                    `FRA_RG_LOCK:    allowed = (op == `FRA_OP_WRITE) || (master == `FRA_MS_DEBUG);
                    `FRA_RG_DEVINFO: allowed = 1'b0;
                    default:         allowed = 1'b0;
                endcase
            end
        end
    endfunction

    // End of a countdown; shared by every timed phase
    function cnt_last;
        input [15:0] cnt;
        begin
            cnt_last = (cnt <= 16'h0001);
        end
    endfunction

    // Sequencer state, countdown and device erase page
    reg [2:0]  state;
    reg [15:0] count;
    reg [4:0]  mass_page;
    reg        wait_left;

    wire ok = allowed(i_req_master, i_req_op, dec_region, i_energy_state);
    // Abort only a page erase; device erase must always finish
    wire abort_now = i_erase_abort_en && i_irq_pending && state == ST_ERASE;

    // Main sequencer
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            state            <= ST_IDLE;
            count            <= 16'h0000;
            mass_page        <= 5'h00;
            wait_left        <= 1'b0;
            o_req_ready      <= 1'b0;
            o_done           <= 1'b0;
            o_bus_error      <= 1'b0;
            o_wait_states    <= 2'h0;
            o_flash_rd       <= 1'b0;
            o_flash_wr       <= 1'b0;
            o_flash_erase    <= 1'b0;
            o_flash_region   <= 3'h0;
            o_flash_page     <= 5'h00;
            o_sram_clear     <= 1'b0;
            o_write_done_evt <= 1'b0;
            o_erase_done_evt <= 1'b0;
            o_erase_aborted  <= 1'b0;
            o_erase_busy     <= 1'b0;
        end else begin
            o_wait_states    <= WS;
            o_req_ready      <= 1'b0;
            o_done           <= 1'b0;
            o_bus_error      <= 1'b0;
            o_write_done_evt <= 1'b0;
            o_erase_done_evt <= 1'b0;
            o_erase_aborted  <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (i_req_valid) begin
                        o_req_ready <= 1'b1;
                        if (!ok) begin
                            o_bus_error <= 1'b1;
                            o_done      <= 1'b1;
                            state       <= ST_DONE;
                        end else begin
                            o_flash_region <= dec_region;
                            o_flash_page   <= dec_page;
                            case (i_req_op)
                                `FRA_OP_READ: begin
                                    o_flash_rd <= 1'b1;
                                    wait_left  <= (WS != 2'h0);
                                    state      <= ST_READ;
                                end
                                `FRA_OP_WRITE: begin
                                    o_flash_wr <= 1'b1;
                                    count      <= WRITE_CYCLES;
                                    state      <= ST_WRITE;
                                end
                                `FRA_OP_ERASE: begin
                                    o_flash_erase <= 1'b1;
                                    count         <= ERASE_CYCLES;
                                    state         <= ST_ERASE;
                                end
                                default: begin
                                    // Device erase touches main pages and then the lock page, never the user page
                                    o_flash_region <= `FRA_RG_MAIN;
                                    o_flash_page   <= 5'h00;
                                    mass_page      <= 5'h00;
                                    o_flash_erase  <= 1'b1;
                                    o_erase_busy   <= 1'b1;
                                    count          <= ERASE_CYCLES;
                                    state          <= ST_MMAIN;
                                end
                            endcase
                        end
                    end
                end

                // Read strobe held one cycle more when a wait state is due
                ST_READ: begin
                    if (wait_left) begin
                        wait_left <= 1'b0;
                    end else begin
                        o_flash_rd <= 1'b0;
                        o_done     <= 1'b1;
                        state      <= ST_DONE;
                    end
                end

                // Write strobe stands for the whole programming time
                ST_WRITE: begin
                    if (cnt_last(count)) begin
                        o_flash_wr       <= 1'b0;
                        o_write_done_evt <= 1'b1;
                        o_done           <= 1'b1;
                        state            <= ST_DONE;
                    end else begin
                        count <= count - 16'h0001;
                    end
                end

                // Page erase; an enabled interrupt cuts it short
                ST_ERASE: begin
                    if (abort_now) begin
                        o_flash_erase   <= 1'b0;
                        o_erase_aborted <= 1'b1;
                        o_done          <= 1'b1;
                        state           <= ST_DONE;
                    end else if (cnt_last(count)) begin
                        o_flash_erase    <= 1'b0;
                        o_erase_done_evt <= 1'b1;
                        o_done           <= 1'b1;
                        state            <= ST_DONE;
                    end else begin
                        count <= count - 16'h0001;
                    end
                end

                ST_MMAIN: begin
                    // Walk every main page in turn
                    if (cnt_last(count)) begin
                        if (mass_page == 5'h1F) begin
                            o_flash_erase <= 1'b0;
                            o_sram_clear  <= 1'b1;
                            count         <= SRAM_CYCLES;
                            state         <= ST_MSRAM;
                        end else begin
                            mass_page    <= mass_page + 5'h01;
                            o_flash_page <= mass_page + 5'h01;
                            count        <= ERASE_CYCLES;
                        end
                    end else begin
                        count <= count - 16'h0001;
                    end
                end

                // SRAM clear runs between main and lock page erase
                ST_MSRAM: begin
                    if (cnt_last(count)) begin
                        o_sram_clear   <= 1'b0;
                        o_flash_region <= `FRA_RG_LOCK;
                        o_flash_page   <= 5'h00;
                        o_flash_erase  <= 1'b1;
                        count          <= ERASE_CYCLES;
                        state          <= ST_MLB;
                    end else begin
                        count <= count - 16'h0001;
                    end
                end

                // Lock page last, so debug unlocks only after a full wipe
                ST_MLB: begin
                    if (cnt_last(count)) begin
                        o_flash_erase    <= 1'b0;
                        o_erase_busy     <= 1'b0;
                        o_erase_done_evt <= 1'b1;
                        o_done           <= 1'b1;
                        state            <= ST_DONE;
                    end else begin
                        count <= count - 16'h0001;
                    end
                end

                ST_DONE: begin
                    // One idle cycle so a held valid is not taken twice
                    state <= ST_IDLE;
                end

                // Unused codes fall back to idle
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// *** tb/fra_access_checker.sv ***
/* Timing and permission checker for fra_access.
   Assumes it is bound to fra_access and sees only its ports. */
`include "fra_consts.vh"
`default_nettype none
module fra_access_checker #(
    parameter        CORE_HZ      = 14000000,
    parameter [15:0] WRITE_CYCLES = 16'h0010
) (
    input wire logic        i_ref_clk,
    input wire logic        i_rst,
    input wire logic [1:0]  i_req_op,
    input wire logic [31:0] i_req_addr,
    input wire logic [1:0]  i_energy_state,
    input wire logic        o_req_ready,
    input wire logic        o_done,
    input wire logic        o_bus_error,
    input wire logic [1:0]  o_wait_states,
    input wire logic        o_flash_wr,
    input wire logic        o_flash_erase,
    input wire logic [2:0]  o_flash_region,
    input wire logic [4:0]  o_flash_page,
    input wire logic        o_sram_clear,
    input wire logic        o_write_done_evt,
    input wire logic        o_erase_done_evt,
    input wire logic        o_erase_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] wr_run;
    logic [31:0] addr_q;
    // Run length of the write strobe; the address as taken
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_run <= 16'h0000;
            addr_q <= 32'h00000000;
        end else begin
            wr_run <= o_flash_wr ? wr_run + 16'h0001 : 16'h0000;
            addr_q <= i_req_addr;
        end
    end
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    a_ready_one_cycle: assert property (o_req_ready |=> !o_req_ready) else $error("ready longer than one cycle");
    a_error_ends_req: assert property (o_bus_error |-> o_done && o_req_ready && !o_flash_wr)
        else $error("bus error outside a refusal");
    a_wait_fixed: assert property (!$past(i_rst) |-> o_wait_states == ((CORE_HZ > 16000000) ? 2'h1 : 2'h0))
        else $error("wrong wait states");
    a_write_length: assert property (o_write_done_evt |-> wr_run == WRITE_CYCLES)
        else $error("write strobe length wrong");
    a_write_evt_end: assert property ($fell(o_flash_wr) |-> o_write_done_evt && o_done)
        else $error("write ended without event");
    a_erase_evt_done: assert property (o_erase_done_evt |-> o_done) else $error("erase event alone");
    a_mass_keeps_user: assert property (o_erase_busy && o_flash_erase |-> o_flash_region != `FRA_RG_USER)
        else $error("user page erased in device erase");
    a_info_read_only: assert property (o_flash_wr || o_flash_erase |-> o_flash_region != `FRA_RG_DEVINFO)
        else $error("info page modified");
    a_sram_in_mass: assert property (o_sram_clear |-> o_erase_busy) else $error("sram clear outside erase");
    a_deep_refused: assert property (o_req_ready && $past(i_energy_state) > `FRA_EM_SLEEP |-> o_bus_error)
        else $error("deep state request served");
    a_reserved_error: assert property (o_req_ready && addr_q >= `FRA_MAIN_TOP && addr_q < `FRA_INFO_BASE
        |-> o_bus_error) else $error("reserved access served");
    a_main_page: assert property (o_req_ready && !o_bus_error && addr_q < `FRA_MAIN_TOP && $past(i_req_op) != 2'h3
        |-> o_flash_region == `FRA_RG_MAIN && o_flash_page == addr_q[14:10]) else $error("main page decode wrong");
endmodule
bind fra_access fra_access_checker #(.CORE_HZ(CORE_HZ), .WRITE_CYCLES(WRITE_CYCLES)) u_fra_access_checker (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_req_op(i_req_op), .i_req_addr(i_req_addr),
    .i_energy_state(i_energy_state), .o_req_ready(o_req_ready), .o_done(o_done), .o_bus_error(o_bus_error),
    .o_wait_states(o_wait_states), .o_flash_wr(o_flash_wr), .o_flash_erase(o_flash_erase),
    .o_flash_region(o_flash_region), .o_flash_page(o_flash_page), .o_sram_clear(o_sram_clear),
    .o_write_done_evt(o_write_done_evt), .o_erase_done_evt(o_erase_done_evt), .o_erase_busy(o_erase_busy));
`default_nettype wire

// *** tb/fra_master_model.sv ***
/* Requester model for the core, DMA and debug masters.
   Assumes the valid/ready handshake of fra_access on one clock. */
`default_nettype none
module fra_master_model (
    input  wire logic        i_ref_clk,
    input  wire logic        i_ready,
    output var  logic        o_valid,
    output var  logic [1:0]  o_master,
    output var  logic [1:0]  o_op,
    output var  logic [31:0] o_addr,
    output var  logic        o_stuck
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle lines start away from any real request
    initial begin
        o_valid = 1'b0;
        o_master = 2'h3;
        o_op = 2'h0;
        o_addr = 32'hFFFFFFFF;
        o_stuck = 1'b0;
    end
    // Request held until ready is sampled high; bounded so a hang ends
    task automatic issue(input logic [1:0] m, input logic [1:0] op, input logic [31:0] a);
        int n;
        o_valid <= 1'b1;
        o_master <= m;
        o_op <= op;
        o_addr <= a;
        n = 0;
        do begin
            @(posedge i_ref_clk);
            n++;
        end while (i_ready !== 1'b1 && n < 50);
        o_stuck = (i_ready !== 1'b1);
        o_valid <= 1'b0;
        o_master <= ~m;
        o_op <= ~op;
        o_addr <= ~a; // Released lines flip, so a stale value never passes
    endtask
endmodule
`default_nettype wire

// *** tb/fra_access_bench.sv ***
/* Self-checking bench for the flash region map and access logic.
   Assumes fra_access with shortened flash timing and the master model. */
`include "fra_consts.vh"
`default_nettype none
module fra_access_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HZ = 20000000;
    localparam int WC = 4;
    localparam int EC = 8;
    localparam int SC = 4;
    localparam logic [31:0] BASES [4] = '{`FRA_MAIN_BASE, `FRA_USER_BASE, `FRA_LOCK_BASE, `FRA_DEVINFO_BASE};
    logic        i_ref_clk, i_rst, abort_en, irq, valid, stuck;
    logic        ready, done, err, rd, wr, er, sram, wevt, eevt, abt, busy;
    logic [1:0]  em, mst, op, ws;
    logic [2:0]  rg;
    logic [4:0]  pg;
    logic [7:0]  seed, ra;
    logic [31:0] addr, a;
    int          num_errors, samples_checked;
    fra_access #(.CORE_HZ(HZ), .WRITE_CYCLES(16'(WC)), .ERASE_CYCLES(16'(EC)), .SRAM_CYCLES(16'(SC))) u_fra_access (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_req_valid(valid), .i_req_master(mst), .i_req_op(op),
        .i_req_addr(addr), .i_energy_state(em), .i_erase_abort_en(abort_en), .i_irq_pending(irq),
        .o_req_ready(ready), .o_done(done), .o_bus_error(err), .o_wait_states(ws), .o_flash_rd(rd),
        .o_flash_wr(wr), .o_flash_erase(er), .o_flash_region(rg), .o_flash_page(pg), .o_sram_clear(sram),
        .o_write_done_evt(wevt), .o_erase_done_evt(eevt), .o_erase_aborted(abt), .o_erase_busy(busy));
    fra_master_model u_fra_master_model (.i_ref_clk(i_ref_clk), .i_ready(ready), .o_valid(valid),
        .o_master(mst), .o_op(op), .o_addr(addr), .o_stuck(stuck));
    // Reference clock, 50 MHz
    initial begin
        i_ref_clk = 1'b0;
        forever #10 i_ref_clk = ~i_ref_clk;
    end
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // Region by address; anything else is reserved
    function automatic logic [2:0] exp_rg(input logic [31:0] x);
        if (x < `FRA_MAIN_TOP) return `FRA_RG_MAIN;
        if ((x & 32'hFFFFFC00) == `FRA_USER_BASE) return `FRA_RG_USER;
        if ((x & 32'hFFFFFC00) == `FRA_LOCK_BASE) return `FRA_RG_LOCK;
        if ((x & 32'hFFFFFC00) == `FRA_DEVINFO_BASE) return `FRA_RG_DEVINFO;
        return `FRA_RG_NONE;
    endfunction
    // Who may do what, where and when
    function automatic logic refuse(input logic [1:0] m, input logic [1:0] o, input logic [1:0] e, input logic [2:0] r);
        return r == `FRA_RG_NONE || e > `FRA_EM_SLEEP
            || (o != `FRA_OP_READ && m == `FRA_MS_CORE && e != `FRA_EM_RUN)
            || (o >= `FRA_OP_ERASE && m != `FRA_MS_CORE && m != `FRA_MS_DEBUG)
            || (r == `FRA_RG_DEVINFO && o != `FRA_OP_READ) || (o == `FRA_OP_MASS && m != `FRA_MS_DEBUG)
            || (r == `FRA_RG_LOCK && o == `FRA_OP_ERASE && m != `FRA_MS_DEBUG);
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // One request from issue to completion, then the idle cycle
    task automatic run(input logic [1:0] m, input logic [1:0] o, input logic [1:0] e, input logic [31:0] x);
        logic bad, ab_case, we, ee, ab, rs, sr, lbl;
        logic [31:0] pages;
        int k;
        bad = refuse(m, o, e, exp_rg(x));
        {we, ee, ab, rs, sr, lbl, pages, k} = '0;
        em <= e;
        u_fra_master_model.issue(m, o, x);
        // Read after an edge, so abort controls set just before the call count
        ab_case = !bad && o == `FRA_OP_ERASE && abort_en && irq;
        if (stuck) begin
            num_errors++;
            $display("wrong value request taken expected 1 seen 0");
            complete_run();
        end
        chk("bus error", bad, err);
        if (!bad && o != `FRA_OP_MASS) chk("region page", {exp_rg(x), x[14:10]}, {rg, pg});
        while (1) begin
            if (er && busy && rg == `FRA_RG_MAIN) pages[pg] = 1'b1;
            if (er && busy && rg == `FRA_RG_LOCK) lbl = sr;
            {we, ee, ab, rs, sr} = {we, ee, ab, rs, sr} | {wevt, eevt, abt, rd, sram};
            if (done === 1'b1 || k == 400) break;
            @(posedge i_ref_clk);
            k++;
        end
        if (k == 400) begin
            num_errors++;
            $display("wrong value request done expected 1 seen 0");
            complete_run();
        end
        if (o == `FRA_OP_MASS && !bad) begin
            chk("main pages erased", 32'hFFFFFFFF, pages);
            chk("lock page after sram", 1'b1, lbl);
            chk("device erase time", 1'b1, k >= 32 * EC + SC + EC && k <= 32 * EC + SC + EC + 40);
        end else if (ab_case) begin
            chk("erase aborted", 1'b1, ab && k <= 3);
        end else begin
            chk("latency", bad ? 0 : o == `FRA_OP_READ ? (HZ > 16000000 ? 2 : 1) : o == `FRA_OP_WRITE ? WC : EC, k);
            chk("events", {!bad && o == `FRA_OP_WRITE, !bad && o == `FRA_OP_ERASE, 1'b0}, {we, ee, ab});
            chk("read strobe", !bad && o == `FRA_OP_READ, rs);
        end
        $display("test master %0d op %0d addr %h ended after %0d cycles", m, o, x, k);
        @(posedge i_ref_clk);
    endtask
    // Reset, directed table, random mix
    initial begin
        {i_rst, em, abort_en, irq, num_errors, samples_checked} = {1'b1, 68'h0};
        seed = 8'h58;
        repeat (8) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        @(posedge i_ref_clk);
        run(`FRA_MS_CORE, `FRA_OP_READ, `FRA_EM_RUN, 32'h00000000);
        chk("wait states", 2'h1, ws);
        run(`FRA_MS_DMA, `FRA_OP_WRITE, `FRA_EM_SLEEP, 32'h00007C08);
        run(`FRA_MS_CORE, `FRA_OP_WRITE, `FRA_EM_SLEEP, 32'h00007C04);
        run(`FRA_MS_CORE, `FRA_OP_READ, `FRA_EM_RUN, 32'h00008000);
        run(`FRA_MS_CORE, `FRA_OP_READ, `FRA_EM_RUN, 32'h0FE10000);
        run(`FRA_MS_CORE, `FRA_OP_READ, `FRA_EM_RUN, 32'h0FE00400);
        run(`FRA_MS_CORE, `FRA_OP_WRITE, `FRA_EM_RUN, 32'h0FE00010);
        run(`FRA_MS_CORE, `FRA_OP_ERASE, `FRA_EM_RUN, 32'h0FE00000);
        run(`FRA_MS_CORE, `FRA_OP_WRITE, `FRA_EM_RUN, 32'h0FE04000);
        run(`FRA_MS_CORE, `FRA_OP_ERASE, `FRA_EM_RUN, 32'h0FE04000);
        run(`FRA_MS_DEBUG, `FRA_OP_ERASE, `FRA_EM_RUN, 32'h0FE04000);
        run(`FRA_MS_DMA, `FRA_OP_READ, `FRA_EM_SLEEP, 32'h0FE08000);
        run(`FRA_MS_CORE, `FRA_OP_WRITE, `FRA_EM_RUN, 32'h0FE08000);
        run(`FRA_MS_DMA, `FRA_OP_READ, 2'h2, 32'h00000400);
        run(`FRA_MS_DMA, `FRA_OP_ERASE, `FRA_EM_RUN, 32'h00000400);
        run(`FRA_MS_CORE, `FRA_OP_MASS, `FRA_EM_RUN, 32'h00000000);
        run(`FRA_MS_DEBUG, `FRA_OP_MASS, `FRA_EM_RUN, 32'h00000000);
        abort_en <= 1'b1;
        irq <= 1'b1;
        run(`FRA_MS_CORE, `FRA_OP_ERASE, `FRA_EM_RUN, 32'h00001000);
        abort_en <= 1'b0;
        irq <= 1'b0;
        for (int i = 0; i < 24; i++) begin
            seed = lfsr(seed);
            ra = lfsr(seed);
            a = BASES[seed[7:6]] + {22'h0, ra, 2'h0};
            if (seed[7:6] == 2'h0) a[14:10] = ra[4:0];
            run(seed[1:0], (seed[3:2] == 2'h3) ? `FRA_OP_READ : seed[3:2], seed[5:4], a);
            seed = ra;
        end
        complete_run();
    end
endmodule
`default_nettype wire
